// ---- inc/mcsc_regs.vh ----
`ifndef MCSC_REGS_VH
`define MCSC_REGS_VH

// ---------------------------------------------------------------
// key codes
// ---------------------------------------------------------------
`define MCSC_K_9 5'h09
`define MCSC_K_DOT 5'h0a
`define MCSC_K_STORE 5'h0b
`define MCSC_K_RECALL 5'h0c
`define MCSC_K_INSPECT 5'h0d
`define MCSC_K_CLEAR 5'h0e
`define MCSC_K_STAR 5'h0f
`define MCSC_K_LOCKOUT 5'h10
`define MCSC_K_SQUELCH 5'h11
`define MCSC_K_DWELL 5'h12
`define MCSC_K_SCAN 5'h13
`define MCSC_K_HANDOFF 5'h14
`define MCSC_K_FW0 5'h15
`define MCSC_K_FW4 5'h19

// ---------------------------------------------------------------
// register offsets and reset values
// ---------------------------------------------------------------
`define MCSC_A_CTRL 4'h0
`define MCSC_A_STATUS 4'h4
`define MCSC_A_CHAN 4'h8
`define MCSC_A_DWELL 4'hc
`define MCSC_MODE_RST 3'h0
`define MCSC_MODE_USB 3'h4
`define MCSC_DWELL_RST 4'h0
`define MCSC_BW_RST 3'h2
`define MCSC_BW_SB 3'h2

// ---------------------------------------------------------------
// channel numbers and commands
// ---------------------------------------------------------------
`define MCSC_CH_MAX 7'd99
`define MCSC_SCAN_MAX 7'd86
`define MCSC_CH_QUICK 7'd0
`define MCSC_DWELL_STOP 4'h9
`define MCSC_CMD_ERASE 10'd999
`define MCSC_CMD_MASTER 10'd25
`define MCSC_CMD_SLAVE 10'd26

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MCSC_CLK_KHZ 100000
`define MCSC_TICK_MS 100
`define MCSC_TICK_CYC (`MCSC_TICK_MS * `MCSC_CLK_KHZ)
`define MCSC_TICKS_PER_S 7'd10
`define MCSC_HANDOFF_TICKS 2'd2
`endif

// ---- hw/mcsc_tick.v ----
`timescale 1ns/10ps
`include "mcsc_regs.vh"
// ---------------------------------------------------------------
// tenth-second tick divider
// ---------------------------------------------------------------
module mcsc_tick #(
  parameter TICK_CYC = `MCSC_TICK_CYC
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire restart_i,
  output reg tick_o
);
  localparam integer LAST_I = TICK_CYC - 1;
  // 24 bits cover any tick period up to about 0.17 s at this clock
  localparam [23:0] LAST = LAST_I[23:0];
  reg [23:0] cnt_q;

  // restart lets a dwell start on a full period instead of a partial one
  always @(posedge core_clk_i)
  begin
    if (reset_i || restart_i)
    begin
      cnt_q <= 24'h0;
      tick_o <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q <= 24'h0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 24'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ---- hw/mcsc_ctrl.v ----
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "mcsc_regs.vh"
// ---------------------------------------------------------------
// memory channel and scan control
// ---------------------------------------------------------------
module mcsc_ctrl #(
  parameter TICK_CYC = `MCSC_TICK_CYC
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire key_valid_i,
  input wire [4:0] key_code_i,
  input wire [15:0] panel_params_i,
  input wire [3:0] sig_level_i,
  input wire handoff_ack_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output reg [15:0] rcv_params_o,
  output reg rcv_load_o,
  output reg [15:0] led_params_o,
  output reg [6:0] channel_number_display_o,
  output reg chan_blank_o,
  output reg [3:0] offset_level_display_o,
  output reg entry_fault_o,
  output reg [2:0] bw_sel_o,
  output reg [4:0] bw_led_o,
  output reg handoff_req_o,
  output reg handoff_led_o
);
  // scan states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_SEEK = 6'h02;
  localparam [5:0] S_SETTLE = 6'h04;
  localparam [5:0] S_CMP = 6'h08;
  localparam [5:0] S_DWELL = 6'h10;
  localparam [5:0] S_HOLD = 6'h20;

  wire tick;
  wire [1599:0] par_all;
  wire [399:0] thr_all;
  wire [99:0] lock_all;
  wire [13:0] acc_x10;
  wire is_dig;
  wire [6:0] ch7;
  wire num_ok;
  wire [9:0] lk_lo;
  wire lk_ok;
  wire sideband;
  wire scan_key;
  wire clr_key;
  wire elig;
  wire scan_rcl;
  wire [6:0] sch_nx;
  wire [4:0] fw_idx;
  reg [9:0] acc_q;
  reg have_q;
  reg dot_q;
  reg [9:0] lo_q;
  reg llock_q;
  reg [6:0] lkl_q;
  reg [6:0] lkh_q;
  reg inspect_key_q;
  reg [6:0] exch_q;
  reg blink_q;
  reg blink_ph_q;
  reg [6:0] cur_ch_q;
  reg qblank_q;
  reg [3:0] dwell_q;
  reg master_q;
  reg [2:0] mode_q;
  reg hwait_q;
  reg [1:0] hcnt_q;
  reg wst_q;
  reg [6:0] wst_idx_q;
  reg wthr_q;
  reg [6:0] wthr_idx_q;
  reg [3:0] wthr_val_q;
  reg wera_q;
  reg wlk_q;
  reg wlk_set_q;
  reg [5:0] st_q;
  reg [6:0] sch_q;
  reg [6:0] tries_q;
  reg [6:0] dcnt_q;
  reg tclr_q;

  // ---------------------------------------------------------------
  // key decode
  // ---------------------------------------------------------------
  assign acc_x10 = {1'b0, acc_q, 3'b000} + {3'b000, acc_q, 1'b0};
  assign is_dig = key_valid_i && (key_code_i <= `MCSC_K_9);
  assign ch7 = acc_q[6:0];
  assign num_ok = have_q && (acc_q >= 10'd1) && (acc_q <= {3'b000, `MCSC_CH_MAX});
  assign lk_lo = dot_q ? lo_q : acc_q;
  assign lk_ok = num_ok && (lk_lo >= 10'd1) && (lk_lo <= acc_q);
  assign sideband = (mode_q >= `MCSC_MODE_USB);
  assign scan_key = key_valid_i && (key_code_i == `MCSC_K_SCAN);
  assign clr_key = key_valid_i && (key_code_i == `MCSC_K_CLEAR);
  assign fw_idx = key_code_i - `MCSC_K_FW0;

  mcsc_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .restart_i(tclr_q),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // channel storage, index 0 is the quick channel
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 100; gi = gi + 1)
    begin : g_ch
      reg [15:0] par_q;
      reg [3:0] thr_q;
      reg lock_q;
      // erase leaves the quick channel and lockouts intact
      always @(posedge core_clk_i)
      begin
        if (reset_i)
        begin
          par_q <= 16'h0;
          thr_q <= 4'h0;
          lock_q <= 1'b0;
        end
        else
        begin
          if (wera_q && (gi != 0))
          begin
            par_q <= 16'h0;
            thr_q <= 4'h0;
          end
          else if (wst_q && (wst_idx_q == gi))
            par_q <= panel_params_i;
          else if (wthr_q && (wthr_idx_q == gi))
            thr_q <= wthr_val_q;
          if (wlk_q && (gi >= lkl_q) && (gi <= lkh_q))
            lock_q <= wlk_set_q;
        end
      end
      assign par_all[16*gi +: 16] = par_q;
      assign thr_all[4*gi +: 4] = thr_q;
      assign lock_all[gi] = lock_q;
    end
  endgenerate

  // ---------------------------------------------------------------
  // scan sequencer
  // ---------------------------------------------------------------
  // sector channels excluded
  assign elig = (sch_q >= 7'd1) && (sch_q <= `MCSC_SCAN_MAX) && !lock_all[sch_q];
  assign sch_nx = (sch_q >= `MCSC_SCAN_MAX) ? 7'd1 : sch_q + 7'd1;
  assign scan_rcl = st_q[1] && elig;

  // a failed search over every slot stops the scan rather than spinning
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      st_q <= S_IDLE;
      sch_q <= 7'd1;
      tries_q <= 7'd0;
      dcnt_q <= 7'd0;
      tclr_q <= 1'b0;
    end
    else
    begin
      tclr_q <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (scan_key)
          begin
            sch_q <= 7'd1;
            tries_q <= 7'd0;
            st_q <= S_SEEK;
          end
        end
        S_SEEK:
        begin
          if (elig)
          begin
            tclr_q <= 1'b1;
            st_q <= S_SETTLE;
          end
          else if (tries_q == `MCSC_SCAN_MAX)
            st_q <= S_IDLE;
          else
          begin
            sch_q <= sch_nx;
            tries_q <= tries_q + 7'd1;
          end
        end
        S_SETTLE:
        begin
          if (tick)
            st_q <= S_CMP;
        end
        S_CMP:
        begin
          tries_q <= 7'd0;
          if (sig_level_i >= thr_all[4*sch_q +: 4])
          begin
            tclr_q <= 1'b1;
            if (dwell_q == `MCSC_DWELL_STOP)
              st_q <= S_HOLD;
            else
            begin
              dcnt_q <= (dwell_q == 4'h0) ? 7'd1 : dwell_q * `MCSC_TICKS_PER_S;
              st_q <= S_DWELL;
            end
          end
          else
          begin
            sch_q <= sch_nx;
            st_q <= S_SEEK;
          end
        end
        S_DWELL:
        begin
          if (tick)
          begin
            dcnt_q <= dcnt_q - 7'd1;
            if (dcnt_q == 7'd1)
            begin
              sch_q <= sch_nx;
              st_q <= S_SEEK;
            end
          end
        end
        S_HOLD:
        begin
          if (scan_key)
          begin
            sch_q <= sch_nx;
            st_q <= S_SEEK;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
      // clear cancels, and scan key stops a running scan except in S_HOLD, where it resumes
      if (clr_key || (scan_key && !st_q[0] && !st_q[5]))
        st_q <= S_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // keypad interpreter
  // ---------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      acc_q <= 10'd0;
      have_q <= 1'b0;
      dot_q <= 1'b0;
      lo_q <= 10'd0;
      llock_q <= 1'b0;
      lkl_q <= 7'd0;
      lkh_q <= 7'd0;
      inspect_key_q <= 1'b0;
      exch_q <= 7'd0;
      blink_q <= 1'b0;
      cur_ch_q <= 7'd1;
      qblank_q <= 1'b1;
      entry_fault_o <= 1'b0;
      dwell_q <= `MCSC_DWELL_RST;
      master_q <= 1'b0;
      bw_sel_o <= `MCSC_BW_RST;
      hwait_q <= 1'b0;
      hcnt_q <= 2'd0;
      handoff_req_o <= 1'b0;
      handoff_led_o <= 1'b0;
      rcv_params_o <= 16'h0;
      rcv_load_o <= 1'b0;
      wst_q <= 1'b0;
      wst_idx_q <= 7'd0;
      wthr_q <= 1'b0;
      wthr_idx_q <= 7'd0;
      wthr_val_q <= 4'h0;
      wera_q <= 1'b0;
      wlk_q <= 1'b0;
      wlk_set_q <= 1'b0;
    end
    else
    begin
      wst_q <= 1'b0;
      wthr_q <= 1'b0;
      wera_q <= 1'b0;
      wlk_q <= 1'b0;
      rcv_load_o <= 1'b0;
      handoff_req_o <= 1'b0;
      if (scan_rcl)
      begin
        rcv_params_o <= par_all[16*sch_q +: 16];
        rcv_load_o <= 1'b1;
      end
      if (hwait_q && handoff_ack_i)
      begin
        hwait_q <= 1'b0;
        hcnt_q <= `MCSC_HANDOFF_TICKS;
      end
      else if (tick && (hcnt_q != 2'd0))
      begin
        hcnt_q <= hcnt_q - 2'd1;
        if (hcnt_q == 2'd1)
          handoff_led_o <= 1'b0;
      end
      if (is_dig)
      begin
        // digits beyond three are dropped; 999 is the longest command
        if (acc_q < 10'd100)
          acc_q <= acc_x10[9:0] + {6'h00, key_code_i[3:0]};
        have_q <= 1'b1;
      end
      else if (key_valid_i)
      begin
        acc_q <= 10'd0;
        have_q <= 1'b0;
        dot_q <= 1'b0;
        llock_q <= 1'b0;
        case (key_code_i)
          `MCSC_K_DOT:
          begin
            lo_q <= acc_q;
            dot_q <= 1'b1;
            llock_q <= llock_q;
          end
          `MCSC_K_STORE, `MCSC_K_RECALL:
          begin
            if (!have_q || num_ok)
            begin
              wst_idx_q <= have_q ? ch7 : `MCSC_CH_QUICK;
              cur_ch_q <= have_q ? ch7 : `MCSC_CH_QUICK;
              qblank_q <= !have_q;
              inspect_key_q <= 1'b0;
              blink_q <= 1'b0;
              entry_fault_o <= 1'b0;
              if (key_code_i == `MCSC_K_STORE)
                wst_q <= 1'b1;
              else
              begin
                rcv_params_o <= par_all[16*(have_q ? ch7 : `MCSC_CH_QUICK) +: 16];
                rcv_load_o <= 1'b1;
              end
            end
            else
              entry_fault_o <= 1'b1;
          end
          `MCSC_K_INSPECT:
          begin
            if (num_ok)
            begin
              exch_q <= ch7;
              blink_q <= 1'b1;
              inspect_key_q <= 1'b1;
            end
            else if (!have_q)
            begin
              exch_q <= ((inspect_key_q ? exch_q : cur_ch_q) >= `MCSC_CH_MAX) ? 7'd1 :
                        (inspect_key_q ? exch_q : cur_ch_q) + 7'd1;
              // quick-channel blanking is kept so clear returns to it
              blink_q <= 1'b0;
              inspect_key_q <= 1'b1;
            end
            else
              entry_fault_o <= 1'b1;
          end
          `MCSC_K_CLEAR:
          begin
            inspect_key_q <= 1'b0;
            blink_q <= 1'b0;
          end
          `MCSC_K_STAR:
          begin
            if (have_q && (acc_q == `MCSC_CMD_ERASE))
              wera_q <= 1'b1;
            else if (have_q && (acc_q == `MCSC_CMD_MASTER))
              master_q <= 1'b1;
            else if (have_q && (acc_q == `MCSC_CMD_SLAVE))
              master_q <= 1'b0;
            else
              entry_fault_o <= 1'b1;
          end
          `MCSC_K_LOCKOUT:
          begin
            // lock, or unlock on second press
            if (lk_ok)
            begin
              lkl_q <= lk_lo[6:0];
              lkh_q <= ch7;
              wlk_q <= 1'b1;
              wlk_set_q <= 1'b1;
              llock_q <= 1'b1;
              entry_fault_o <= 1'b0;
            end
            else if (!have_q && llock_q)
            begin
              wlk_q <= 1'b1;
              wlk_set_q <= 1'b0;
            end
            else
              entry_fault_o <= 1'b1;
          end
          `MCSC_K_SQUELCH:
          begin
            if (have_q && (acc_q <= 10'd9))
            begin
              wthr_q <= 1'b1;
              wthr_idx_q <= cur_ch_q;
              wthr_val_q <= acc_q[3:0];
              entry_fault_o <= 1'b0;
            end
            else
              entry_fault_o <= 1'b1;
          end
          `MCSC_K_DWELL:
          begin
            if (have_q && (acc_q <= 10'd9))
            begin
              dwell_q <= acc_q[3:0];
              entry_fault_o <= 1'b0;
            end
            else
              entry_fault_o <= 1'b1;
          end
          `MCSC_K_HANDOFF:
          begin
            handoff_led_o <= 1'b1;
            hcnt_q <= 2'd0;
            if (master_q)
            begin
              handoff_req_o <= 1'b1;
              hwait_q <= 1'b1;
            end
          end
          default:
          begin
            if ((key_code_i >= `MCSC_K_FW0) && (key_code_i <= `MCSC_K_FW4) && !sideband)
              bw_sel_o <= fw_idx[2:0];
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // panel displays and register port
  // ---------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      blink_ph_q <= 1'b0;
      led_params_o <= 16'h0;
      channel_number_display_o <= 7'd0;
      chan_blank_o <= 1'b1;
      offset_level_display_o <= 4'h0;
      bw_led_o <= 5'h04;
      mode_q <= `MCSC_MODE_RST;
      rdata_o <= 8'h00;
    end
    else
    begin
      if (tick)
        blink_ph_q <= !blink_ph_q;
      led_params_o <= inspect_key_q ? par_all[16*exch_q +: 16] : panel_params_i;
      channel_number_display_o <= inspect_key_q ? exch_q : cur_ch_q;
      chan_blank_o <= inspect_key_q ? (blink_q && blink_ph_q) : qblank_q;
      offset_level_display_o <= thr_all[4*(inspect_key_q ? exch_q : cur_ch_q) +: 4];
      bw_led_o <= 5'h01 << (sideband ? `MCSC_BW_SB : bw_sel_o);
      if (wr_i && (addr_i == `MCSC_A_CTRL))
        mode_q <= wdata_i[2:0];
      rdata_o <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          `MCSC_A_CTRL: rdata_o <= {5'h00, mode_q};
          `MCSC_A_STATUS: rdata_o <= {3'h0, handoff_led_o, master_q, st_q[5], !st_q[0], inspect_key_q};
          `MCSC_A_CHAN: rdata_o <= {1'b0, st_q[0] ? cur_ch_q : sch_q};
          `MCSC_A_DWELL: rdata_o <= {4'h0, dwell_q};
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ---- testbench/mcsc_ctrl_checker.sv ----
`timescale 1ns/10ps
`include "mcsc_regs.vh"
// ---------------------------------------------------------------
// port checker for the channel controller
// ---------------------------------------------------------------
module mcsc_checker (
  input wire core_clk_i,
  input wire reset_i,
  input wire key_valid_i,
  input wire [4:0] key_code_i,
  input wire handoff_ack_i,
  input wire [15:0] rcv_params_o,
  input wire rcv_load_o,
  input wire [6:0] channel_number_display_o,
  input wire chan_blank_o,
  input wire [3:0] offset_level_display_o,
  input wire [2:0] bw_sel_o,
  input wire [4:0] bw_led_o,
  input wire handoff_req_o,
  input wire handoff_led_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic ack_seen_q;
  logic hand_key;
  // remember an ack while the lamp is lit; the lamp may only go dark after one
  always @(posedge core_clk_i)
  begin
    if (reset_i || !handoff_led_o)
      ack_seen_q <= 1'b0;
    else if (handoff_ack_i)
      ack_seen_q <= 1'b1;
  end
  assign hand_key = key_valid_i && (key_code_i == `MCSC_K_HANDOFF);
  sequence s_hand_key;
    key_valid_i && (key_code_i == `MCSC_K_HANDOFF);
  endsequence
  sequence s_lamp_soon;
    ##[1:2] handoff_led_o;
  endsequence
  a_handoff_from_key: assert property (
    handoff_req_o |-> $past(hand_key) || $past(hand_key, 2))
    else $error("hand-off request without key");
  a_lamp_on_key: assert property (s_hand_key |-> s_lamp_soon)
    else $error("hand-off lamp not lit after key");
  a_req_lights_lamp: assert property (handoff_req_o |-> ##[0:1] handoff_led_o)
    else $error("request without lamp");
  a_lamp_needs_ack: assert property ($fell(handoff_led_o) |-> ack_seen_q)
    else $error("lamp dark without acknowledge");
  a_rcv_only_load: assert property ($changed(rcv_params_o) |-> rcv_load_o)
    else $error("receiver word changed without load");
  a_chan_in_range: assert property (
    !chan_blank_o |-> channel_number_display_o inside {[7'd1:7'd99]})
    else $error("channel display out of range");
  a_level_digit: assert property (offset_level_display_o <= 4'h9)
    else $error("threshold above nine");
  a_width_onehot: assert property ($onehot(bw_led_o))
    else $error("width lamps not one-hot");
  a_width_range: assert property (bw_sel_o <= 3'h4)
    else $error("width index above four");
endmodule
bind mcsc_ctrl mcsc_checker u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .key_valid_i(key_valid_i), .key_code_i(key_code_i), .handoff_ack_i(handoff_ack_i),
  .rcv_params_o(rcv_params_o), .rcv_load_o(rcv_load_o),
  .channel_number_display_o(channel_number_display_o), .chan_blank_o(chan_blank_o),
  .offset_level_display_o(offset_level_display_o), .bw_sel_o(bw_sel_o),
  .bw_led_o(bw_led_o), .handoff_req_o(handoff_req_o), .handoff_led_o(handoff_led_o));

// ---- testbench/mcsc_far_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// receiver and remote link stand-in
// ---------------------------------------------------------------
module mcsc_far_model #(
  parameter ACK_DLY = 7
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire [15:0] rcv_params_i,
  input wire rcv_load_i,
  input wire handoff_req_i,
  output logic [3:0] sig_level_o,
  output logic handoff_ack_o
);
  int cnt_q;
  // strong signal only on the marker word; level follows each load
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      sig_level_o <= 4'h0;
    else if (rcv_load_i)
      sig_level_o <= (rcv_params_i == 16'h00aa) ? 4'hf : 4'h0;
  end
  // slow link: ack comes some cycles after the request, as a pulse
  always @(posedge core_clk_i)
  begin
    handoff_ack_o <= (cnt_q == 1);
    if (reset_i)
      cnt_q <= 0;
    else if (handoff_req_i)
      cnt_q <= ACK_DLY;
    else if (cnt_q != 0)
      cnt_q <= cnt_q - 1;
  end
endmodule

// ---- testbench/mcsc_ctrl_test.sv ----
`timescale 1ns/10ps
`include "mcsc_regs.vh"
module mcsc_ctrl_test;
  logic clk, rst, kv, wr, rd, rl, cb, ef, hr, hl, ha;
  logic [4:0] kc, bl;
  logic [15:0] panel, rp, lp;
  logic [3:0] addr, lvl, ol;
  logic [7:0] wd, rdat, d;
  logic [6:0] cn;
  logic [2:0] bs;
  int miscompares = 0, checks_done = 0, reqs = 0, hits = 0, seen87 = 0;
  // ---------------------------------------------------------------
  // block and far side
  // ---------------------------------------------------------------
  mcsc_ctrl #(.TICK_CYC(20)) dut (.core_clk_i(clk), .reset_i(rst), .key_valid_i(kv),
    .key_code_i(kc), .panel_params_i(panel), .sig_level_i(lvl), .handoff_ack_i(ha),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .rcv_params_o(rp),
    .rcv_load_o(rl), .led_params_o(lp), .channel_number_display_o(cn), .chan_blank_o(cb),
    .offset_level_display_o(ol), .entry_fault_o(ef), .bw_sel_o(bs), .bw_led_o(bl),
    .handoff_req_o(hr), .handoff_led_o(hl));
  mcsc_far_model #(.ACK_DLY(7)) far (.core_clk_i(clk), .reset_i(rst), .rcv_params_i(rp),
    .rcv_load_i(rl), .handoff_req_i(hr), .sig_level_o(lvl), .handoff_ack_o(ha));
  // clock and request counter
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (hr === 1'b1) reqs <= reqs + 1;
  // receiver loads of the marker word and of the sector-slot word
  always @(posedge clk) if (rl === 1'b1 && rp === 16'h00aa) hits <= hits + 1;
  always @(posedge clk) if (rl === 1'b1 && rp === 16'h0087) seen87 <= seen87 + 1;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input [15:0] s, input [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task key(input [4:0] c);
    @(posedge clk); kv <= 1'b1; kc <= c;
    @(posedge clk); kv <= 1'b0;
  endtask
  // two-digit entry goes most significant digit first
  task digs(input [6:0] n);
    if (n > 9) key(5'(n / 10));
    key(5'(n % 10));
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task setp(input [15:0] p);
    @(posedge clk); panel <= p;
  endtask
  task wreg(input [3:0] a, input [7:0] v);
    @(posedge clk); addr <= a; wd <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rreg(input [3:0] a, output [7:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdat;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_mem;
    setp(16'h1234); digs(5); key(`MCSC_K_STORE);
    setp(16'h5555); digs(5); key(`MCSC_K_RECALL);
    // the load pulse stands for one cycle only
    idle(0); chk(16'(rl), 16'h1);
    chk(rp, 16'h1234);
    idle(2); chk(16'(cn), 16'h5);
    chk(16'(cb), 16'h0);
    setp(16'habcd); key(`MCSC_K_STORE); setp(16'h0); key(`MCSC_K_RECALL);
    idle(3); chk(rp, 16'habcd);
    chk(16'(cb), 16'h1);
  endtask
  task t_inspect;
    setp(16'h7777); digs(5); key(`MCSC_K_INSPECT);
    idle(3); chk(lp, 16'h1234);
    chk(rp, 16'habcd);
    key(`MCSC_K_CLEAR); idle(3); chk(lp, 16'h7777);
    digs(99); key(`MCSC_K_INSPECT); key(`MCSC_K_INSPECT);
    idle(3); chk(16'(cn), 16'h1);
    key(`MCSC_K_CLEAR);
    repeat (3) key(`MCSC_K_9);
    key(`MCSC_K_STAR); key(5'h00); key(`MCSC_K_STORE);
    idle(1); chk(16'(ef), 16'h1);
    digs(5); key(`MCSC_K_RECALL);
    idle(3); chk(rp, 16'h0);
    chk(16'(ef), 16'h0);
  endtask
  task t_width;
    for (int i = 0; i < 5; i++)
    begin
      key(`MCSC_K_FW0 + 5'(i)); idle(3);
      chk(16'(bs), 16'(i));
      chk(16'(bl), 16'(5'h01 << i));
    end
    wreg(`MCSC_A_CTRL, 8'(`MCSC_MODE_USB)); rreg(`MCSC_A_CTRL, d);
    chk(16'(d), 16'h4);
    key(`MCSC_K_FW0); idle(3); chk(16'(bl), 16'h4);
    rreg(4'h2, d); chk(16'(d), 16'h0);
    wreg(`MCSC_A_CTRL, 8'h00);
  endtask
  task t_handoff;
    key(`MCSC_K_HANDOFF); idle(100); chk(16'(reqs), 16'h0);
    chk(16'(hl), 16'h1);
    digs(25); key(`MCSC_K_STAR); key(`MCSC_K_HANDOFF); idle(100);
    chk(16'(reqs), 16'h1);
    chk(16'(hl), 16'h0);
    digs(26); key(`MCSC_K_STAR); key(`MCSC_K_HANDOFF); idle(100);
    chk(16'(reqs), 16'h1);
  endtask
  // scan holds where it stops, so the channel register shows the hit
  task scan_hit(input [7:0] ch);
    key(`MCSC_K_SCAN); idle(300); rreg(`MCSC_A_CHAN, d);
    chk(16'(d), 16'(ch));
    key(`MCSC_K_CLEAR);
  endtask
  task t_scan;
    setp(16'h00aa); digs(2); key(`MCSC_K_STORE); digs(1); key(`MCSC_K_RECALL);
    key(5'h05); key(`MCSC_K_SQUELCH); idle(3); chk(16'(ol), 16'h5);
    key(`MCSC_K_9); key(`MCSC_K_DWELL); key(`MCSC_K_SCAN); idle(300);
    rreg(`MCSC_A_STATUS, d); chk(16'(d[1]), 16'h1);
    rreg(`MCSC_A_CHAN, d); chk(16'(d), 16'h2);
    idle(300); chk(rp, 16'h00aa);
    key(`MCSC_K_CLEAR);
    digs(2); key(`MCSC_K_LOCKOUT); scan_hit(8'h03);
    key(5'h02); key(`MCSC_K_DOT); key(5'h04); key(`MCSC_K_LOCKOUT); scan_hit(8'h05);
    key(5'h02); key(`MCSC_K_DOT); key(5'h04);
    key(`MCSC_K_LOCKOUT); key(`MCSC_K_LOCKOUT); scan_hit(8'h02);
  endtask
  // a short dwell resumes and wraps; the sector slots never come up
  task t_dwell;
    int h0;
    setp(16'h0087); digs(87); key(`MCSC_K_STORE);
    key(5'h03); key(`MCSC_K_DOT); digs(86); key(`MCSC_K_LOCKOUT);
    key(5'h00); key(`MCSC_K_DWELL); rreg(`MCSC_A_DWELL, d);
    chk(16'(d), 16'h0);
    h0 = hits;
    key(`MCSC_K_SCAN); idle(600); rreg(`MCSC_A_STATUS, d);
    chk(16'(d[1]), 16'h1);
    key(`MCSC_K_CLEAR);
    chk(16'(hits - h0 >= 2), 16'h1);
    chk(16'(seen87), 16'h0);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1; kv = 1'b0; kc = 5'h00; panel = 16'h0000;
    wr = 1'b0; rd = 1'b0; addr = 4'h0; wd = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    idle(1); chk(16'(bs), 16'h2);
    chk(16'(bl), 16'h4);
    chk(16'(cb), 16'h1);
    t_mem;
    t_inspect;
    t_width;
    t_handoff;
    t_scan;
    t_dwell;
    give_verdict;
  end
  // the whole run needs a few thousand cycles
  initial
  begin
    #300000;
    miscompares++;
    give_verdict;
  end
endmodule
